// ### core/rios_consts.svh
// Constants for the remote I/O serial link: rates, framing, block sizes.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef RIOS_CONSTS_SVH
`define RIOS_CONSTS_SVH
`define RIOS_CLK_HZ      25000000
`define RIOS_DIV_110     ((`RIOS_CLK_HZ / 110) / 16)
`define RIOS_DIV_300     ((`RIOS_CLK_HZ / 300) / 16)
`define RIOS_DIV_1200    ((`RIOS_CLK_HZ / 1200) / 16)
`define RIOS_DIV_2400    ((`RIOS_CLK_HZ / 2400) / 16)
`define RIOS_DIV_9600    ((`RIOS_CLK_HZ / 9600) / 16)
`define RIOS_DIV_19200   ((`RIOS_CLK_HZ / 19200) / 16)
`define RIOS_DIV_57600   ((`RIOS_CLK_HZ / 57600) / 16)
`define RIOS_OVS         4'hf
`define RIOS_OVS_MID     4'h7
`define RIOS_BITS_SLOW   4'hc
`define RIOS_BITS_FAST   4'hb
`define RIOS_BLK_SMALL   9'h080
`define RIOS_BLK_LARGE   9'h100
`define RIOS_STATUS_REFS 9'h008
`define RIOS_RATE_DFLT   3'h6
`define RIOS_PAR_DFLT    2'h1
`define RIOS_LINK_TMO    24'h1e8480
`endif

// ### core/rios_pkg.sv
// Types for the remote I/O serial link.
// Assumes rios_consts.svh supplies the numeric constants.
package rios_pkg;
  typedef enum logic [2:0] {
    RIOS_B110, RIOS_B300, RIOS_B1200, RIOS_B2400,
    RIOS_B9600, RIOS_B19200, RIOS_B57600
  } rios_rate_e;
  typedef enum logic [1:0] {
    RIOS_PAR_NONE, RIOS_PAR_ODD, RIOS_PAR_EVEN
  } rios_par_e;
  typedef enum logic [1:0] {
    RIOS_TX_IDLE, RIOS_TX_SHIFT
  } rios_txst_e;
  typedef enum logic [1:0] {
    RIOS_RX_IDLE, RIOS_RX_SHIFT
  } rios_rxst_e;
endpackage : rios_pkg

// ### core/rios_link.sv
// Serial link of a remote I/O driver: frames a block of bytes plus a
// checksum byte out on one line and checks the answer coming back.
// Assumes a 25 MHz clock, a static configuration and a user byte source.
`timescale 1ns/1ns
`include "rios_consts.svh"

// Contract
// RQ1: A block holds 128 or 256 references, chosen by a static setting.
// RQ2: Eight references of each block carry controller status only.
// RQ3: Bit rate is one of seven settings, same at both ends.
// RQ4: Characters are 12 bits at 110 baud, otherwise 11 bits.
// RQ5: Default configuration is 57.6K baud, 11 bits, odd parity.
// RQ6: A checksum byte ends each message and is verified on receive.
// RQ7: With hold selected, outputs keep last values after a failure.
// RQ8: Unless continue is selected, faults and link failures halt the CPU; the code does not halt on DRIVER_FAULT.
// RQ9: Separate driver, link and remote station fault indications.
// RQ10: One transmit line and one receive line carry data and control.
// RQ11: The far end accepts messages sent back to back.
// RQ12: Start bit, eight data bits LSB first, optional parity, stop bits.
module rios_link (
  input  wire logic        CLK,          // 25 MHz clock
  input  wire logic        RST_N,        // Synchronous reset, active low
  input  wire logic        CFG_DEFAULT,  // Use default rate and format
  input  wire logic [2:0]  CFG_RATE,     // Rate select
  input  wire logic [1:0]  CFG_PARITY,   // 0 none, 1 odd, 2 even
  input  wire logic        CFG_BLK_LARGE,// 1 selects 256 references
  input  wire logic        CFG_HOLD,     // Hold outputs on failure
  input  wire logic        CFG_CONTINUE, // Keep CPU running on faults
  input  wire logic        CPU_FAIL,     // CPU failure from local side
  input  wire logic        REMOTE_FAULT, // Remote station fault report
  input  wire logic        TX_START,     // Start one message
  input  wire logic [7:0]  TX_DATA,      // Byte for next slot
  input  wire logic [7:0]  STATUS_DATA,  // Byte for status slots
  output logic             TX_NEXT,      // Byte consumed pulse
  output logic [8:0]       TX_INDEX,     // Slot being sent
  output logic             TX_BUSY,      // Message in progress
  input  wire logic        RXD,          // Receive line
  output logic             TXD,          // Transmit line
  output logic [7:0]       RX_DATA,      // Received byte
  output logic             RX_VALID,     // Received byte pulse
  output logic [7:0]       OUT_IMAGE,    // Last output byte held
  output logic             DRIVER_FAULT, // Driver fault indication
  output logic             LINK_FAULT,   // Serial link fault
  output logic             STATION_FAULT,// Remote station fault
  output logic             CPU_HALT      // Request to stop the CPU
);

  // Pick the divider for one sixteenth of a bit
  function automatic logic [15:0] rate_div(input logic [2:0] r);
    unique case (r)
      3'h0:    rate_div = 16'(`RIOS_DIV_110);
      3'h1:    rate_div = 16'(`RIOS_DIV_300);
      3'h2:    rate_div = 16'(`RIOS_DIV_1200);
      3'h3:    rate_div = 16'(`RIOS_DIV_2400);
      3'h4:    rate_div = 16'(`RIOS_DIV_9600);
      3'h5:    rate_div = 16'(`RIOS_DIV_19200);
      default: rate_div = 16'(`RIOS_DIV_57600);
    endcase
  endfunction : rate_div

  logic [2:0]  rate;
  logic [1:0]  par;
  logic [3:0]  nbits;
  logic [8:0]  blk_len;
  logic [15:0] div_reg, div_next;
  logic        tick;

  // Effective configuration
  always_comb begin
    rate    = CFG_DEFAULT ? `RIOS_RATE_DFLT : CFG_RATE; // RQ5 RQ3
    par     = CFG_DEFAULT ? `RIOS_PAR_DFLT : CFG_PARITY; // RQ5
    nbits   = (rate == 3'h0) ? `RIOS_BITS_SLOW : `RIOS_BITS_FAST; // RQ4
    blk_len = CFG_BLK_LARGE ? `RIOS_BLK_LARGE : `RIOS_BLK_SMALL; // RQ1
  end

  // Oversample tick divider
  always_comb begin
    div_next = div_reg + 16'h0001;
    tick     = 1'b0;
    if (div_reg >= rate_div(rate) - 16'h0001) begin // RQ3
      div_next = 16'h0000;
      tick     = 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) div_reg <= 16'h0000;
    else        div_reg <= div_next;
  end

  // Builds the character shift pattern with parity and stop fill
  function automatic logic [11:0] frame(input logic [7:0] d,
                                        input logic [1:0] p);
    logic pb;
    pb = ^d ^ (p == 2'h1);
    if (p == 2'h0) frame = {3'h7, d, 1'b0}; // RQ12
    else           frame = {2'h3, pb, d, 1'b0}; // RQ12
  endfunction : frame

  // Transmitter
  rios_pkg::rios_txst_e tx_st_reg, tx_st_next;
  logic [11:0] tx_sh_reg, tx_sh_next;
  logic [3:0]  tx_os_reg, tx_os_next, tx_bit_reg, tx_bit_next;
  logic [8:0]  tx_idx_reg, tx_idx_next;
  logic [7:0]  tx_sum_reg, tx_sum_next, img_reg, img_next;
  logic        tx_last_reg, tx_last_next, txd_reg, txd_next;
  logic        next_p;
  logic [7:0]  byte_now;
  logic        failure;
  logic [8:0]  slot_in;

  // Slot about to be loaded picks status or user data
  assign failure  = CPU_FAIL | LINK_FAULT;
  assign slot_in  = tx_idx_reg + 9'h001;
  assign byte_now = (slot_in < `RIOS_STATUS_REFS) ? STATUS_DATA
                                                  : TX_DATA; // RQ2

  always_comb begin
    tx_st_next   = tx_st_reg;
    tx_sh_next   = tx_sh_reg;
    tx_os_next   = tx_os_reg;
    tx_bit_next  = tx_bit_reg;
    tx_idx_next  = tx_idx_reg;
    tx_sum_next  = tx_sum_reg;
    tx_last_next = tx_last_reg;
    img_next     = img_reg;
    txd_next     = txd_reg;
    next_p       = 1'b0;
    unique case (tx_st_reg)
      rios_pkg::RIOS_TX_IDLE: begin
        txd_next = 1'b1;
        if (TX_START) begin
          tx_st_next   = rios_pkg::RIOS_TX_SHIFT;
          tx_idx_next  = 9'h000;
          tx_sum_next  = 8'h00;
          tx_last_next = 1'b0;
          tx_sh_next   = frame(STATUS_DATA, par);
          tx_os_next   = 4'h0;
          tx_bit_next  = 4'h0;
          next_p       = 1'b1;
          tx_sum_next  = STATUS_DATA;
        end
      end
      rios_pkg::RIOS_TX_SHIFT: begin
        if (tick) begin
          txd_next   = tx_sh_reg[0]; // RQ10
          tx_os_next = tx_os_reg + 4'h1;
          if (tx_os_reg == `RIOS_OVS) begin
            tx_sh_next  = {1'b1, tx_sh_reg[11:1]};
            tx_bit_next = tx_bit_reg + 4'h1;
            if (tx_bit_reg == nbits - 4'h1) begin // RQ4
              tx_bit_next = 4'h0;
              if (tx_last_reg) begin
                tx_st_next = rios_pkg::RIOS_TX_IDLE;
              end else if (tx_idx_reg == blk_len - 9'h001) begin
                tx_last_next = 1'b1;
                tx_sh_next   = frame(tx_sum_reg, par); // RQ6
              end else begin
                tx_idx_next = slot_in;
                tx_sh_next  = frame(byte_now, par); // RQ2
                next_p      = 1'b1;
                tx_sum_next = tx_sum_reg + byte_now; // RQ6
              end
            end
          end
        end
      end
      default: tx_st_next = rios_pkg::RIOS_TX_IDLE;
    endcase
    // Image follows each loaded byte unless held through a failure
    if (next_p && !(CFG_HOLD && failure)) // RQ7
      img_next = (tx_st_reg == rios_pkg::RIOS_TX_IDLE) ? STATUS_DATA
                                                       : byte_now;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_st_reg   <= rios_pkg::RIOS_TX_IDLE;
      tx_sh_reg   <= 12'hfff;
      tx_os_reg   <= 4'h0;
      tx_bit_reg  <= 4'h0;
      tx_idx_reg  <= 9'h000;
      tx_sum_reg  <= 8'h00;
      tx_last_reg <= 1'b0;
      img_reg     <= 8'h00;
      txd_reg     <= 1'b1;
    end else begin
      tx_st_reg   <= tx_st_next;
      tx_sh_reg   <= tx_sh_next;
      tx_os_reg   <= tx_os_next;
      tx_bit_reg  <= tx_bit_next;
      tx_idx_reg  <= tx_idx_next;
      tx_sum_reg  <= tx_sum_next;
      tx_last_reg <= tx_last_next;
      img_reg     <= img_next;
      txd_reg     <= txd_next;
    end
  end

  assign TXD       = txd_reg;
  assign TX_NEXT   = next_p;
  assign TX_INDEX  = tx_idx_reg;
  assign TX_BUSY   = (tx_st_reg != rios_pkg::RIOS_TX_IDLE);
  assign OUT_IMAGE = img_reg;

  // Receive line synchroniser
  logic rx_s1_reg, rx_s2_reg;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= RXD;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // Receiver: samples mid bit, counts bytes, checks parity and checksum
  rios_pkg::rios_rxst_e rx_st_reg, rx_st_next;
  logic [3:0]  rx_os_reg, rx_os_next, rx_bit_reg, rx_bit_next;
  logic [9:0]  rx_sh_reg, rx_sh_next;
  logic [8:0]  rx_cnt_reg, rx_cnt_next;
  logic [7:0]  rx_sum_reg, rx_sum_next, rx_d_reg, rx_d_next;
  logic        rx_v_reg, rx_v_next, perr_reg, perr_next;
  logic        serr_reg, serr_next;
  logic [23:0] tmo_reg, tmo_next;

  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_os_next  = rx_os_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_sum_next = rx_sum_reg;
    rx_d_next   = rx_d_reg;
    rx_v_next   = 1'b0;
    perr_next   = perr_reg;
    serr_next   = serr_reg;
    tmo_next    = (tmo_reg == `RIOS_LINK_TMO) ? tmo_reg : tmo_reg + 24'h1;
    unique case (rx_st_reg)
      rios_pkg::RIOS_RX_IDLE: begin
        if (tick && !rx_s2_reg) begin
          rx_st_next  = rios_pkg::RIOS_RX_SHIFT;
          rx_os_next  = 4'h0;
          rx_bit_next = 4'h0;
        end
      end
      rios_pkg::RIOS_RX_SHIFT: begin
        if (tick) begin
          rx_os_next = rx_os_reg + 4'h1;
          if (rx_os_reg == `RIOS_OVS_MID) begin
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg <= 4'h9)
              rx_sh_next = {rx_s2_reg, rx_sh_reg[9:1]}; // RQ12
            // Sample 9 is parity or first stop; data sits in sh[9:2]
            if (rx_bit_reg == 4'h9) begin
              tmo_next  = 24'h0;
              rx_d_next = rx_sh_reg[9:2]; // RQ12
              if (par != 2'h0 &&
                  (^{rx_s2_reg, rx_sh_reg[9:2]} ^ (par == 2'h1)))
                perr_next = 1'b1; // RQ4
              if (rx_cnt_reg == blk_len) begin // RQ6
                if (rx_sum_reg != rx_sh_reg[9:2])
                  serr_next = 1'b1;
                rx_cnt_next = 9'h000;
                rx_sum_next = 8'h00;
              end else begin
                rx_v_next   = 1'b1;
                rx_cnt_next = rx_cnt_reg + 9'h001;
                rx_sum_next = rx_sum_reg + rx_sh_reg[9:2];
              end
            end
            // With parity, wait for the stop bit before hunting a start
            if (rx_bit_reg == ((par == 2'h0) ? 4'h9 : 4'ha))
              rx_st_next = rios_pkg::RIOS_RX_IDLE; // RQ11
          end
        end
      end
      default: rx_st_next = rios_pkg::RIOS_RX_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_st_reg  <= rios_pkg::RIOS_RX_IDLE;
      rx_os_reg  <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg  <= 10'h3ff;
      rx_cnt_reg <= 9'h000;
      rx_sum_reg <= 8'h00;
      rx_d_reg   <= 8'h00;
      rx_v_reg   <= 1'b0;
      perr_reg   <= 1'b0;
      serr_reg   <= 1'b0;
      tmo_reg    <= 24'h0;
    end else begin
      rx_st_reg  <= rx_st_next;
      rx_os_reg  <= rx_os_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg  <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_sum_reg <= rx_sum_next;
      rx_d_reg   <= rx_d_next;
      rx_v_reg   <= rx_v_next;
      perr_reg   <= perr_next;
      serr_reg   <= serr_next;
      tmo_reg    <= tmo_next;
    end
  end

  // Fault indications and halt request
  assign RX_DATA       = rx_d_reg;
  assign RX_VALID      = rx_v_reg;
  assign DRIVER_FAULT  = serr_reg; // RQ9
  assign LINK_FAULT    = (tmo_reg == `RIOS_LINK_TMO); // RQ9
  assign STATION_FAULT = REMOTE_FAULT | perr_reg; // RQ9
  assign CPU_HALT      = !CFG_CONTINUE &&
                         (STATION_FAULT || LINK_FAULT); // RQ8

  // Halt follows station faults unless continue is set
  property p_halt;
    @(posedge CLK) disable iff (!RST_N)
      (STATION_FAULT && !CFG_CONTINUE) |-> CPU_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("halt missing"); // RQ8

  // Hold keeps output image during failure
  property p_hold;
    @(posedge CLK) disable iff (!RST_N)
      (CFG_HOLD && failure) |=> $stable(img_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("image moved"); // RQ7

  // Line idles high when no message
  property p_idle;
    @(posedge CLK) disable iff (!RST_N)
      (tx_st_reg == rios_pkg::RIOS_TX_IDLE) [*2] |-> TXD;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle"); // RQ12

  // Slot index never passes block length
  property p_blk;
    @(posedge CLK) disable iff (!RST_N) TX_INDEX < blk_len;
  endproperty
  a_blk: assert property (p_blk) else $error("index too large"); // RQ1

  // Status slots come first: a status slot load shifts STATUS_DATA
  property p_stat;
    @(posedge CLK) disable iff (!RST_N)
      (TX_NEXT && (!TX_BUSY || slot_in < `RIOS_STATUS_REFS))
        |=> tx_sh_reg[8:1] == $past(STATUS_DATA);
  endproperty
  a_stat: assert property (p_stat) else $error("status slot"); // RQ2

  // A twelfth bit is only ever sent at the slowest rate
  property p_len;
    @(posedge CLK) disable iff (!RST_N)
      (TX_BUSY && tx_bit_reg == `RIOS_BITS_FAST) |-> rate == 3'h0;
  endproperty
  a_len: assert property (p_len) else $error("bad length"); // RQ4

  // Default settings
  property p_dflt;
    @(posedge CLK) disable iff (!RST_N)
      CFG_DEFAULT |-> (rate == 3'h6 && par == 2'h1);
  endproperty
  a_dflt: assert property (p_dflt) else $error("bad default"); // RQ5

  // Received byte pulse is one cycle
  property p_rxv;
    @(posedge CLK) disable iff (!RST_N) RX_VALID |=> !RX_VALID;
  endproperty
  a_rxv: assert property (p_rxv) else $error("long valid"); // RQ6

endmodule : rios_link

// ### tb/rios_peer.sv
// Far-end model of the serial link: decodes the driver's line and sends
// characters back. Assumes the bench sets bit length and format fields.
`timescale 1ns/1ns
module rios_peer (
  input  wire logic clk,      // System clock
  input  wire logic line_in,  // Driver transmit line
  output logic      line_out  // Line back to the driver
);
  int unsigned bit_cyc   = 432;  // Cycles per bit, same rate both ends
  int unsigned char_bits = 11;   // Bits per character
  logic [1:0]  par_mode  = 2'h1; // 0 none, 1 odd, 2 even
  logic [7:0]  got_q[$];         // Decoded bytes
  int unsigned frame_err = 0;    // Framing or parity faults seen

  // Idle line rests at mark level
  initial line_out = 1'b1;

  // Decode one character per pass, sampling at mid-bit
  always begin : decode
    logic [7:0] b;
    wait (line_in === 1'b1);
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge clk);
    if (line_in !== 1'b0) frame_err++;
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      b[i] = line_in;
    end
    if (par_mode != 2'h0) begin
      repeat (bit_cyc) @(posedge clk);
      if (line_in !== (^b ^ (par_mode == 2'h1))) frame_err++;
    end
    for (int i = 9 + (par_mode != 2'h0); i < char_bits; i++) begin
      repeat (bit_cyc) @(posedge clk);
      if (line_in !== 1'b1) frame_err++;
    end
    got_q.push_back(b);
  end

  // Drop a half-decoded character, e.g. across a reset
  task automatic clear;
    disable decode;
    got_q.delete();
    frame_err = 0;
  endtask : clear

  // Send one framed character, no gap after it; bad parity on request
  task automatic send_char(input logic [7:0] d, input logic bad_par);
    logic [11:0] fr;
    fr = 12'hfff;
    fr[0] = 1'b0;
    fr[8:1] = d;
    if (par_mode != 2'h0) fr[9] = ^d ^ (par_mode == 2'h1) ^ bad_par;
    for (int i = 0; i < char_bits; i++) begin
      @(posedge clk);
      #1 line_out = fr[i];
      repeat (bit_cyc - 1) @(posedge clk);
    end
  endtask : send_char
endmodule : rios_peer

// ### tb/remote_io_serial_link_bench.sv
// Testbench of the remote I/O serial link: transmit framing per rate and
// format, receive path and fault flags. Assumes rios_peer on the line.
`timescale 1ns/1ns
`include "rios_consts.svh"
module remote_io_serial_link_bench;
  logic        clk, rst_n, cfg_default, cfg_blk_large, cfg_hold;
  logic        cfg_continue, cpu_fail, remote_fault, tx_start, tx_next;
  logic        tx_busy, rxd, txd, rx_valid, driver_fault, link_fault;
  logic        station_fault, cpu_halt;
  logic [2:0]  cfg_rate;
  logic [1:0]  cfg_parity;
  logic [7:0]  tx_data, status_data, rx_data, out_image;
  logic [8:0]  tx_index;
  logic [7:0]  rx_q[$];
  logic [7:0]  rx_pat[3] = '{8'h01, 8'h80, 8'hc5};
  int unsigned num_errors = 0;
  int unsigned total_checks = 0;
  int unsigned nxt_cnt = 0;

  rios_link rios_link_i (
    .CLK(clk), .RST_N(rst_n), .CFG_DEFAULT(cfg_default),
    .CFG_RATE(cfg_rate), .CFG_PARITY(cfg_parity),
    .CFG_BLK_LARGE(cfg_blk_large), .CFG_HOLD(cfg_hold),
    .CFG_CONTINUE(cfg_continue), .CPU_FAIL(cpu_fail),
    .REMOTE_FAULT(remote_fault), .TX_START(tx_start), .TX_DATA(tx_data),
    .STATUS_DATA(status_data), .TX_NEXT(tx_next), .TX_INDEX(tx_index),
    .TX_BUSY(tx_busy), .RXD(rxd), .TXD(txd), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .OUT_IMAGE(out_image),
    .DRIVER_FAULT(driver_fault), .LINK_FAULT(link_fault),
    .STATION_FAULT(station_fault), .CPU_HALT(cpu_halt));

  rios_peer rios_peer_i (.clk(clk), .line_in(txd), .line_out(rxd));

  // Data slots carry a pattern of the preceding slot's index
  assign tx_data = tx_index[7:0] ^ 8'h5a;

  // Clock of 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Log every received byte
  always @(posedge clk) if (rx_valid === 1'b1) rx_q.push_back(rx_data);

  // Count bytes taken by the transmitter
  always @(posedge clk) if (tx_next === 1'b1) nxt_cnt++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Reset for six cycles; outputs must be quiet meanwhile
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (6) tick();
    check(txd, 1'h1);
    check({tx_busy, driver_fault, link_fault, station_fault}, 4'h0);
    rios_peer_i.clear();
    rst_n = 1'b1;
    tick();
  endtask : do_reset

  // Send a message and check its first status characters on the line
  task automatic tx_case(input logic dflt, input logic [2:0] rate,
                         input logic [1:0] par, input logic [7:0] stat,
                         input int unsigned nch);
    int unsigned bc;
    bc = 16 * ((!dflt && rate == 3'h5) ? `RIOS_DIV_19200 : `RIOS_DIV_57600);
    tick();
    cfg_default = dflt;
    cfg_rate = rate;
    cfg_parity = par;
    status_data = stat;
    rios_peer_i.bit_cyc = bc;
    rios_peer_i.par_mode = dflt ? 2'h1 : par;
    do_reset();
    nxt_cnt = 0;
    tx_start = 1'b1;
    tick();
    tx_start = 1'b0;
    check(tx_busy, 1'h1);
    check(out_image, stat);
    repeat (bc * 4) tick();
    tx_start = 1'b1;
    tick();
    tx_start = 1'b0;
    for (int k = 0; k < nch * 12 * bc && rios_peer_i.got_q.size() < nch; k++)
      @(posedge clk);
    tick();
    check(rios_peer_i.got_q.size(), nch);
    for (int k = 0; k < nch; k++) check(rios_peer_i.got_q[k], stat);
    check(rios_peer_i.frame_err, 16'h0);
    check(nxt_cnt, nch);
    check(tx_index, 16'(nch - 1));
  endtask : tx_case

  // Hold keeps the output image through a failure, release lets it follow
  task automatic hold_case;
    logic [7:0] held;
    tick();
    held = status_data;
    check(out_image, held);
    cfg_hold = 1'b1;
    cpu_fail = 1'b1;
    status_data = ~held;
    repeat (12 * 16 * `RIOS_DIV_57600) tick();
    check(out_image, held);
    cpu_fail = 1'b0;
    repeat (12 * 16 * `RIOS_DIV_57600) tick();
    check(out_image, status_data);
    cfg_hold = 1'b0;
  endtask : hold_case

  // Receive bytes back to back, then parity and station faults
  task automatic rx_case;
    tick();
    cfg_default = 1'b1;
    rios_peer_i.bit_cyc = 16 * `RIOS_DIV_57600;
    rios_peer_i.par_mode = 2'h1;
    do_reset();
    rx_q.delete();
    foreach (rx_pat[k]) rios_peer_i.send_char(rx_pat[k], 1'b0);
    repeat (rios_peer_i.bit_cyc) tick();
    check(rx_q.size(), 16'h3);
    foreach (rx_pat[k]) check(rx_q[k], rx_pat[k]);
    check(station_fault, 1'h0);
    rios_peer_i.send_char(8'h7e, 1'b1);
    repeat (rios_peer_i.bit_cyc) tick();
    check({station_fault, link_fault, cpu_halt}, 3'h5);
    cfg_continue = 1'b1;
    #1 check(cpu_halt, 1'h0);
    tick();
    cfg_continue = 1'b0;
    do_reset();
    remote_fault = 1'b1;
    repeat (2) tick();
    check({station_fault, driver_fault, cpu_halt}, 3'h5);
  endtask : rx_case

  // Main sequence; all inputs get a value at time zero
  initial begin
    {cfg_default, cfg_blk_large, cfg_hold, cfg_continue} = 4'h0;
    {cpu_fail, remote_fault, tx_start, rst_n} = 4'h0;
    cfg_rate = 3'h0;
    cfg_parity = 2'h0;
    status_data = 8'h00;
    tx_case(1'b1, 3'h0, 2'h2, 8'h96, 2);
    cfg_blk_large = 1'b1;
    tx_case(1'b0, 3'h6, 2'h2, 8'h3c, 2);
    tx_case(1'b0, 3'h6, 2'h0, 8'he1, 2);
    hold_case();
    tx_case(1'b0, 3'h5, 2'h1, 8'h0f, 1);
    rx_case();
    end_of_test();
  end

  // Watchdog a quarter past the expected run length
  initial begin
    #3600000;
    num_errors++;
    end_of_test();
  end
endmodule : remote_io_serial_link_bench
